// ### src/temp_alarm_pkg.sv
// constants, types and helpers shared by the temperature alarm design
package temp_alarm_pkg;

	localparam int CLK_HZ = 50_000_000;
	localparam int CONV_PERIOD_MS = 250;
	localparam int CONV_PERIOD_CYC = CLK_HZ / 1000 * CONV_PERIOD_MS;
	localparam int BUS_TIMEOUT_MS = 30;
	localparam int BUS_TIMEOUT_CYC = CLK_HZ / 1000 * BUS_TIMEOUT_MS;

	localparam logic [6:0] ARA_ADDR = 7'h0c;
	// arbitrary identification value
	localparam logic [7:0] DEVICE_ID = 8'h5a;

	localparam logic [7:0] CMD_LOCAL_TEMP = 8'h00;
	localparam logic [7:0] CMD_REMOTE_TEMP = 8'h01;
	localparam logic [7:0] CMD_STATUS1 = 8'h02;
	localparam logic [7:0] CMD_CFG_RD = 8'h03;
	localparam logic [7:0] CMD_RATE_RD = 8'h04;
	localparam logic [7:0] CMD_LHI_RD = 8'h05;
	localparam logic [7:0] CMD_LLO_RD = 8'h06;
	localparam logic [7:0] CMD_RHI_RD = 8'h07;
	localparam logic [7:0] CMD_RLO_RD = 8'h08;
	localparam logic [7:0] CMD_CFG_WR = 8'h09;
	localparam logic [7:0] CMD_RATE_WR = 8'h0a;
	localparam logic [7:0] CMD_LHI_WR = 8'h0b;
	localparam logic [7:0] CMD_LLO_WR = 8'h0c;
	localparam logic [7:0] CMD_RHI_WR = 8'h0d;
	localparam logic [7:0] CMD_RLO_WR = 8'h0e;
	localparam logic [7:0] CMD_ONE_SHOT = 8'h0f;
	localparam logic [7:0] CMD_STATUS2 = 8'h12;
	localparam logic [7:0] CMD_OT2_REMOTE = 8'h16;
	localparam logic [7:0] CMD_OT2_LOCAL = 8'h17;
	localparam logic [7:0] CMD_OT1_REMOTE = 8'h19;
	localparam logic [7:0] CMD_OT1_LOCAL = 8'h20;
	localparam logic [7:0] CMD_OVERTEMP_HYSTERESIS = 8'h21;
	localparam logic [7:0] CMD_ID = 8'hfe;

	localparam logic [7:0] RST_POINTER = 8'h00;
	localparam logic [7:0] RST_CFG = 8'h00;
	localparam logic [7:0] RST_RATE = 8'h06;
	localparam logic [7:0] RST_HIGH_LIMIT = 8'h46;
	localparam logic [7:0] RST_LOW_LIMIT = 8'hc9;
	localparam logic [7:0] RST_OT2_REMOTE = 8'h78;
	localparam logic [7:0] RST_OT2_LOCAL = 8'h5a;
	localparam logic [7:0] RST_OT1_REMOTE = 8'h5a;
	localparam logic [7:0] RST_OT1_LOCAL = 8'h46;
	localparam logic [7:0] RST_OVERTEMP_HYSTERESIS = 8'h0a;

	localparam int CFG_MASK_ALL = 7;
	localparam int CFG_STANDBY = 6;
	localparam int CFG_FAULT_QUEUE = 5;
	localparam int CFG_REMOTE2_SEL = 3;
	localparam int CFG_BUS_TIMEOUT_OFF = 2;
	localparam int CFG_MASK_CH2 = 1;
	localparam int CFG_MASK_CH1 = 0;
	// bit 4 is reserved and reads zero
	localparam logic [7:0] CFG_WR_MASK = 8'hef;
	localparam logic [7:0] RATE_WR_MASK = 8'h07;

	localparam logic [2:0] QUEUE_NEED_CH1 = 3'h4;
	localparam logic [2:0] QUEUE_NEED_CH2 = 3'h2;

	typedef enum logic [2:0] {
		LK_IDLE = 3'b000,
		LK_ADDR = 3'b001,
		LK_ACK_OUT = 3'b010,
		LK_RX = 3'b011,
		LK_TX = 3'b100,
		LK_ACK_IN = 3'b101,
		LK_IGNORE = 3'b110
	} link_state_e;

	// true when temp has fallen below limit minus the hysteresis magnitude
	function automatic logic below_release(input logic [7:0] temp,
		input logic [7:0] limit, input logic [7:0] overtemp_hysteresis);
		logic signed [8:0] t;
		logic signed [8:0] r;
		t = {temp[7], temp};
		r = $signed({limit[7], limit}) - $signed({2'b00, overtemp_hysteresis[6:0]});
		return t < r;
	endfunction

	function automatic logic at_or_above(input logic [7:0] a,
		input logic [7:0] b);
		return $signed(a) >= $signed(b);
	endfunction

endpackage

// ### src/ot_comparator.sv
// one overtemperature comparator with shared hysteresis
`timescale 1ns/100ps
`default_nettype none
module ot_comparator
	import temp_alarm_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [7:0] temp,
	input wire logic [7:0] limit,
	input wire logic [7:0] overtemp_hysteresis,
	input wire logic assess,
	input wire logic allow_set,
	output logic over,
	output logic active
);
	logic active_ff;
	logic nxt_active;

	always_comb begin
		over = at_or_above(temp, limit);
		nxt_active = active_ff;
		if (assess) begin
			if (over && allow_set) begin
				nxt_active = 1'b1;
			end else if (below_release(temp, limit, overtemp_hysteresis)) begin
				nxt_active = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			active_ff <= 1'b0;
		end else begin
			active_ff <= nxt_active;
		end
	end

	assign active = active_ff;
endmodule
`default_nettype wire

// ### src/smbus_link.sv
// smbus slave bit engine with alert response arbitration and timeout
`timescale 1ns/100ps
`default_nettype none
module smbus_link
	import temp_alarm_pkg::*;
#(
	parameter int TIMEOUT_CYC = BUS_TIMEOUT_CYC
)(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic [6:0] own_addr,
	input wire logic timeout_off,
	input wire logic ara_pending,
	input wire logic [7:0] tx_byte,
	output logic sda_out,
	output logic sda_oe,
	output logic own_write,
	output logic wr_strobe,
	output logic [7:0] wr_data,
	output logic rd_load,
	output logic rd_done,
	output logic ara_won
);
	localparam int TW = $clog2(TIMEOUT_CYC + 1);
	localparam logic [TW-1:0] TMO_LAST = TW'(TIMEOUT_CYC - 1);

	logic scl_m_ff, scl_s_ff, scl_p_ff, sda_m_ff, sda_s_ff, sda_p_ff;
	link_state_e st_ff, nxt_st;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [7:0] sh_ff, nxt_sh;
	logic oe_ff, nxt_oe, ara_ff, nxt_ara, to_tx_ff, nxt_to_tx;
	logic [TW-1:0] tmo_ff, nxt_tmo;
	logic nxt_own_write, nxt_wr_strobe, nxt_rd_load, nxt_rd_done;
	logic nxt_ara_won, own_write_ff, wr_strobe_ff, rd_load_ff;
	logic rd_done_ff, ara_won_ff;
	logic rise, fall, start, stop;
	logic [7:0] load_byte;

	always_comb begin
		rise = scl_s_ff & ~scl_p_ff;
		fall = ~scl_s_ff & scl_p_ff;
		start = scl_s_ff & scl_p_ff & sda_p_ff & ~sda_s_ff;
		stop = scl_s_ff & scl_p_ff & ~sda_p_ff & sda_s_ff;
		load_byte = ara_ff ? {own_addr, 1'b0} : tx_byte;
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_sh = sh_ff;
		nxt_oe = oe_ff;
		nxt_ara = ara_ff;
		nxt_to_tx = to_tx_ff;
		nxt_own_write = 1'b0;
		nxt_wr_strobe = 1'b0;
		nxt_rd_load = 1'b0;
		nxt_rd_done = 1'b0;
		nxt_ara_won = 1'b0;
		nxt_tmo = (st_ff != LK_IDLE && !scl_s_ff) ? tmo_ff + 1'b1 : '0;
		if (tmo_ff == TMO_LAST && !timeout_off) begin
			nxt_st = LK_IDLE;
			nxt_oe = 1'b0;
			nxt_tmo = '0;
		end else if (start) begin
			nxt_st = LK_ADDR;
			nxt_cnt = 4'h0;
			nxt_oe = 1'b0;
			nxt_ara = 1'b0;
		end else if (stop) begin
			nxt_st = LK_IDLE;
			nxt_oe = 1'b0;
		end else begin
			case (st_ff)
			LK_ADDR: begin
				if (rise) begin
					nxt_sh = {sh_ff[6:0], sda_s_ff};
					nxt_cnt = cnt_ff + 4'h1;
				end else if (fall && cnt_ff == 4'h8) begin
					if (sh_ff[7:1] == own_addr) begin
						nxt_st = LK_ACK_OUT;
						nxt_oe = 1'b1;
						nxt_to_tx = sh_ff[0];
						nxt_own_write = ~sh_ff[0];
					end else if (sh_ff[7:1] == ARA_ADDR && sh_ff[0] &&
						ara_pending) begin
						nxt_st = LK_ACK_OUT;
						nxt_oe = 1'b1;
						nxt_to_tx = 1'b1;
						nxt_ara = 1'b1;
					end else begin
						nxt_st = LK_IGNORE;
					end
				end
			end
			LK_ACK_OUT: begin
				if (fall) begin
					nxt_cnt = 4'h0;
					if (to_tx_ff) begin
						nxt_sh = load_byte;
						nxt_oe = ~load_byte[7];
						nxt_rd_load = ~ara_ff;
						nxt_st = LK_TX;
					end else begin
						nxt_oe = 1'b0;
						nxt_st = LK_RX;
					end
				end
			end
			LK_RX: begin
				if (rise) begin
					nxt_sh = {sh_ff[6:0], sda_s_ff};
					nxt_cnt = cnt_ff + 4'h1;
				end else if (fall && cnt_ff == 4'h8) begin
					nxt_wr_strobe = 1'b1;
					nxt_oe = 1'b1;
					nxt_to_tx = 1'b0;
					nxt_st = LK_ACK_OUT;
				end
			end
			LK_TX: begin
				if (rise) begin
					nxt_cnt = cnt_ff + 4'h1;
					if (!oe_ff && !sda_s_ff) begin
						nxt_st = LK_IGNORE;
					end
				end else if (fall) begin
					if (cnt_ff == 4'h8) begin
						nxt_oe = 1'b0;
						nxt_st = LK_ACK_IN;
					end else begin
						nxt_sh = {sh_ff[6:0], 1'b0};
						nxt_oe = ~sh_ff[6];
					end
				end
			end
			LK_ACK_IN: begin
				if (rise) begin
					nxt_rd_done = ~ara_ff;
					nxt_ara_won = ara_ff;
					if (ara_ff || sda_s_ff) begin
						nxt_st = LK_IGNORE;
					end else begin
						nxt_st = LK_ACK_OUT;
						nxt_to_tx = 1'b1;
					end
				end
			end
			default: begin
				nxt_st = st_ff;
			end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			{scl_m_ff, scl_s_ff, scl_p_ff} <= 3'h7;
			{sda_m_ff, sda_s_ff, sda_p_ff} <= 3'h7;
			st_ff <= LK_IDLE;
			cnt_ff <= 4'h0;
			sh_ff <= 8'h00;
			oe_ff <= 1'b0;
			ara_ff <= 1'b0;
			to_tx_ff <= 1'b0;
			tmo_ff <= '0;
			{own_write_ff, wr_strobe_ff, rd_load_ff} <= 3'h0;
			{rd_done_ff, ara_won_ff} <= 2'h0;
		end else begin
			scl_m_ff <= scl_in;
			scl_s_ff <= scl_m_ff;
			scl_p_ff <= scl_s_ff;
			sda_m_ff <= sda_in;
			sda_s_ff <= sda_m_ff;
			sda_p_ff <= sda_s_ff;
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			sh_ff <= nxt_sh;
			oe_ff <= nxt_oe;
			ara_ff <= nxt_ara;
			to_tx_ff <= nxt_to_tx;
			tmo_ff <= nxt_tmo;
			own_write_ff <= nxt_own_write;
			wr_strobe_ff <= nxt_wr_strobe;
			rd_load_ff <= nxt_rd_load;
			rd_done_ff <= nxt_rd_done;
			ara_won_ff <= nxt_ara_won;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = oe_ff;
	assign own_write = own_write_ff;
	assign wr_strobe = wr_strobe_ff;
	assign wr_data = sh_ff;
	assign rd_load = rd_load_ff;
	assign rd_done = rd_done_ff;
	assign ara_won = ara_won_ff;
endmodule
`default_nettype wire

// ### src/temp_sensor_alarm_control.sv
// alarm, overtemperature, conversion and register control of the sensor
`timescale 1ns/100ps
`default_nettype none
module temp_sensor_alarm_control
	import temp_alarm_pkg::*;
#(
	parameter int CONV_CYC = CONV_PERIOD_CYC,
	parameter int TIMEOUT_CYC = BUS_TIMEOUT_CYC
)(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [6:0] own_addr,
	output logic alert_out,
	output logic alert_oe,
	output logic first_overtemp_output_b,
	output logic second_overtemp_output_b,
	output logic conv_start,
	input wire logic conv_done,
	input wire logic [7:0] local_temp,
	input wire logic [7:0] remote1_temp,
	input wire logic [7:0] remote2_temp,
	input wire logic remote1_open,
	input wire logic remote2_open
);
	localparam logic [23:0] PERIOD_LAST = 24'(CONV_CYC - 1);

	logic [6:0] addr_m_ff, addr_s_ff;
	logic [7:0] ptr_ff, nxt_ptr, cfg_ff, nxt_cfg, rate_ff, nxt_rate;
	logic [7:0] lhi_ff, nxt_lhi, llo_ff, nxt_llo, ot1l_ff, nxt_ot1l;
	logic [7:0] ot2l_ff, nxt_ot2l, overtemp_hysteresis_ff, nxt_overtemp_hysteresis;
	logic [7:0] rhi_ff [2], nxt_rhi [2], rlo_ff [2], nxt_rlo [2];
	logic [7:0] ot1r_ff [2], nxt_ot1r [2], ot2r_ff [2], nxt_ot2r [2];
	logic [7:0] rt_ff [2], nxt_rt [2], lt_ff, nxt_lt;
	logic [1:0] open_ff, nxt_open;
	logic [2:0] q_ff [2], nxt_q [2], q_inc [2], q_need [2];
	logic [1:0] qual;
	logic expect_cmd_ff, nxt_expect_cmd, busy_ff, nxt_busy;
	logic eval_ff, nxt_eval, recheck_ff, nxt_recheck;
	logic alert_ff, nxt_alert, start_ff, one_shot;
	logic [23:0] timer_ff, nxt_timer;
	logic [6:0] st1_ff, nxt_st1, st1_set;
	logic [7:1] st2_ff, nxt_st2, st2_set;
	logic ot1_b_ff, ot2_b_ff, start, stat_clr, cause;
	logic [7:0] tx_byte, wr_data;
	logic own_write, wr_strobe, rd_done, ara_won, sel;
	logic [2:0] ot1_over, ot1_act, ot2_over, ot2_act;
	logic lhi_f, llo_f;
	logic [1:0] rhi_f, rlo_f;

	smbus_link #(
		.TIMEOUT_CYC(TIMEOUT_CYC)
	) link (
		.mclk(mclk),
		.rst_b(rst_b),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.own_addr(addr_s_ff),
		.timeout_off(cfg_ff[CFG_BUS_TIMEOUT_OFF]),
		.ara_pending(alert_ff & ~cfg_ff[CFG_BUS_TIMEOUT_OFF]),
		.tx_byte(tx_byte),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.own_write(own_write),
		.wr_strobe(wr_strobe),
		.wr_data(wr_data),
		.rd_load(),
		.rd_done(rd_done),
		.ara_won(ara_won)
	);

	// comparator order: local, remote 1, remote 2
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_ot
			logic [7:0] t, l1, l2;
			assign t = (gi == 0) ? lt_ff : rt_ff[(gi == 2) ? 1 : 0];
			assign l1 = (gi == 0) ? ot1l_ff : ot1r_ff[(gi == 2) ? 1 : 0];
			assign l2 = (gi == 0) ? ot2l_ff : ot2r_ff[(gi == 2) ? 1 : 0];
			ot_comparator ot1 (
				.mclk(mclk),
				.rst_b(rst_b),
				.temp(t),
				.limit(l1),
				.overtemp_hysteresis(overtemp_hysteresis_ff),
				.assess(eval_ff | recheck_ff),
				.allow_set(eval_ff),
				.over(ot1_over[gi]),
				.active(ot1_act[gi])
			);
			// second output of a remote channel waits on queue when enabled; local one does not
			ot_comparator ot2 (
				.mclk(mclk),
				.rst_b(rst_b),
				.temp(t),
				.limit(l2),
				.overtemp_hysteresis(overtemp_hysteresis_ff),
				.assess(eval_ff | recheck_ff),
				.allow_set(eval_ff & ((gi == 0) | qual[(gi == 2) ? 1 : 0])),
				.over(ot2_over[gi]),
				.active(ot2_act[gi])
			);
		end
	endgenerate

	always_comb begin
		sel = cfg_ff[CFG_REMOTE2_SEL];
		q_need[0] = QUEUE_NEED_CH1;
		q_need[1] = QUEUE_NEED_CH2;
		for (int i = 0; i < 2; i++) begin
			q_inc[i] = (q_ff[i] == 3'h7) ? q_ff[i] : q_ff[i] + 3'h1;
			qual[i] = ~cfg_ff[CFG_FAULT_QUEUE] | (q_inc[i] >= q_need[i]);
			rhi_f[i] = $signed(rt_ff[i]) > $signed(rhi_ff[i]);
			rlo_f[i] = $signed(rt_ff[i]) < $signed(rlo_ff[i]);
		end
		lhi_f = $signed(lt_ff) > $signed(lhi_ff);
		llo_f = $signed(lt_ff) < $signed(llo_ff);
		st1_set = {lhi_f, llo_f, rhi_f[0], rlo_f[0], open_ff[0],
			ot1_over[1], ot1_over[0]};
		st2_set = {ot2_over[0], ot2_over[2], ot2_over[1], rhi_f[1],
			rlo_f[1], open_ff[1], ot1_over[2]};
		// masks gate remote alert causes per channel and all causes globally
		// limits and open diodes raise alert
		cause = ~cfg_ff[CFG_MASK_ALL] & ((lhi_f | llo_f) |
			(~cfg_ff[CFG_MASK_CH1] & (rhi_f[0] | rlo_f[0] | open_ff[0])) |
			(~cfg_ff[CFG_MASK_CH2] & (rhi_f[1] | rlo_f[1] | open_ff[1])));
		case (ptr_ff)
		CMD_LOCAL_TEMP: tx_byte = lt_ff;
		CMD_REMOTE_TEMP: tx_byte = rt_ff[sel];
		// busy shown live in top bit
		CMD_STATUS1: tx_byte = {busy_ff, st1_ff};
		CMD_STATUS2: tx_byte = {st2_ff, 1'b0};
		CMD_CFG_RD: tx_byte = cfg_ff;
		CMD_RATE_RD: tx_byte = rate_ff;
		CMD_LHI_RD: tx_byte = lhi_ff;
		CMD_LLO_RD: tx_byte = llo_ff;
		CMD_RHI_RD: tx_byte = rhi_ff[sel];
		CMD_RLO_RD: tx_byte = rlo_ff[sel];
		CMD_OT2_REMOTE: tx_byte = ot2r_ff[sel];
		CMD_OT2_LOCAL: tx_byte = ot2l_ff;
		CMD_OT1_REMOTE: tx_byte = ot1r_ff[sel];
		CMD_OT1_LOCAL: tx_byte = ot1l_ff;
		CMD_OVERTEMP_HYSTERESIS: tx_byte = overtemp_hysteresis_ff;
		CMD_ID: tx_byte = DEVICE_ID;
		default: tx_byte = 8'h00;
		endcase
	end

	// register writes and command pointer
	always_comb begin
		nxt_ptr = ptr_ff;
		nxt_cfg = cfg_ff;
		nxt_rate = rate_ff;
		nxt_lhi = lhi_ff;
		nxt_llo = llo_ff;
		nxt_ot1l = ot1l_ff;
		nxt_ot2l = ot2l_ff;
		nxt_overtemp_hysteresis = overtemp_hysteresis_ff;
		nxt_rhi = rhi_ff;
		nxt_rlo = rlo_ff;
		nxt_ot1r = ot1r_ff;
		nxt_ot2r = ot2r_ff;
		nxt_expect_cmd = expect_cmd_ff | own_write;
		nxt_recheck = 1'b0;
		one_shot = 1'b0;
		if (wr_strobe && expect_cmd_ff) begin
			nxt_ptr = wr_data;
			nxt_expect_cmd = 1'b0;
			one_shot = (wr_data == CMD_ONE_SHOT);
		end else if (wr_strobe) begin
			case (ptr_ff)
			CMD_CFG_WR: nxt_cfg = wr_data & CFG_WR_MASK;
			CMD_RATE_WR: nxt_rate = wr_data & RATE_WR_MASK;
			CMD_LHI_WR: nxt_lhi = wr_data;
			CMD_LLO_WR: nxt_llo = wr_data;
			CMD_RHI_WR: nxt_rhi[sel] = wr_data;
			CMD_RLO_WR: nxt_rlo[sel] = wr_data;
			CMD_OT2_REMOTE: nxt_ot2r[sel] = wr_data;
			CMD_OT2_LOCAL: nxt_ot2l = wr_data;
			CMD_OT1_REMOTE: nxt_ot1r[sel] = wr_data;
			CMD_OT1_LOCAL: nxt_ot1l = wr_data;
			// magnitude stored as written, bit 7 ignored
			CMD_OVERTEMP_HYSTERESIS: nxt_overtemp_hysteresis = wr_data;
			default: nxt_ptr = ptr_ff;
			endcase
			nxt_recheck = (ptr_ff == CMD_OVERTEMP_HYSTERESIS) || (ptr_ff == CMD_OT1_LOCAL) ||
				(ptr_ff == CMD_OT2_LOCAL) || (ptr_ff == CMD_OT1_REMOTE) ||
				(ptr_ff == CMD_OT2_REMOTE);
		end
	end

	// conversion timing, status and alert
	always_comb begin
		// one-shot or timer expiry starts a conversion
		start = ~busy_ff & (one_shot |
			(~cfg_ff[CFG_STANDBY] & timer_ff == 24'h0));
		nxt_timer = timer_ff;
		if (start) begin
			nxt_timer = PERIOD_LAST;
		end else if (~cfg_ff[CFG_STANDBY] && timer_ff != 24'h0) begin
			nxt_timer = timer_ff - 24'h1;
		end
		nxt_busy = busy_ff;
		nxt_eval = 1'b0;
		nxt_lt = lt_ff;
		nxt_rt = rt_ff;
		nxt_open = open_ff;
		if (start) begin
			nxt_busy = 1'b1;
		end else if (busy_ff && conv_done) begin
			nxt_busy = 1'b0;
			nxt_eval = 1'b1;
			nxt_lt = local_temp;
			nxt_rt[0] = remote1_temp;
			nxt_rt[1] = remote2_temp;
			nxt_open = {remote2_open, remote1_open};
		end
		// standby write aborts a running conversion
		if (nxt_cfg[CFG_STANDBY] && !cfg_ff[CFG_STANDBY]) begin
			nxt_busy = 1'b0;
			nxt_eval = 1'b0;
		end
		nxt_q = q_ff;
		if (eval_ff) begin
			nxt_q[0] = ot2_over[1] ? q_inc[0] : 3'h0;
			nxt_q[1] = ot2_over[2] ? q_inc[1] : 3'h0;
		end
		// status read clears flags; new event wins
		stat_clr = rd_done & (ptr_ff == CMD_STATUS1 | ptr_ff == CMD_STATUS2);
		nxt_st1 = (stat_clr ? 7'h00 : st1_ff) | (eval_ff ? st1_set : 7'h00);
		nxt_st2 = (stat_clr ? 7'h00 : st2_ff) | (eval_ff ? st2_set : 7'h00);
		// latched until status read or response won
		// set again at conversion end if fault stays
		// set only once per finished conversion
		nxt_alert = (alert_ff & ~(stat_clr | ara_won)) | (eval_ff & cause);
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			addr_m_ff <= 7'h00;
			addr_s_ff <= 7'h00;
			ptr_ff <= RST_POINTER;
			cfg_ff <= RST_CFG;
			rate_ff <= RST_RATE;
			lhi_ff <= RST_HIGH_LIMIT;
			llo_ff <= RST_LOW_LIMIT;
			ot1l_ff <= RST_OT1_LOCAL;
			ot2l_ff <= RST_OT2_LOCAL;
			overtemp_hysteresis_ff <= RST_OVERTEMP_HYSTERESIS;
			for (int i = 0; i < 2; i++) begin
				rhi_ff[i] <= RST_HIGH_LIMIT;
				rlo_ff[i] <= RST_LOW_LIMIT;
				ot1r_ff[i] <= RST_OT1_REMOTE;
				ot2r_ff[i] <= RST_OT2_REMOTE;
				rt_ff[i] <= 8'h00;
				q_ff[i] <= 3'h0;
			end
			lt_ff <= 8'h00;
			open_ff <= 2'h0;
			{expect_cmd_ff, recheck_ff, busy_ff, eval_ff} <= 4'h0;
			{alert_ff, start_ff, ot1_b_ff, ot2_b_ff} <= 4'h3;
			timer_ff <= 24'h0;
			st1_ff <= 7'h00;
			st2_ff <= 7'h00;
		end else begin
			addr_m_ff <= own_addr;
			addr_s_ff <= addr_m_ff;
			ptr_ff <= nxt_ptr;
			cfg_ff <= nxt_cfg;
			rate_ff <= nxt_rate;
			lhi_ff <= nxt_lhi;
			llo_ff <= nxt_llo;
			ot1l_ff <= nxt_ot1l;
			ot2l_ff <= nxt_ot2l;
			overtemp_hysteresis_ff <= nxt_overtemp_hysteresis;
			rhi_ff <= nxt_rhi;
			rlo_ff <= nxt_rlo;
			ot1r_ff <= nxt_ot1r;
			ot2r_ff <= nxt_ot2r;
			rt_ff <= nxt_rt;
			q_ff <= nxt_q;
			lt_ff <= nxt_lt;
			open_ff <= nxt_open;
			expect_cmd_ff <= nxt_expect_cmd;
			recheck_ff <= nxt_recheck;
			busy_ff <= nxt_busy;
			eval_ff <= nxt_eval;
			alert_ff <= nxt_alert;
			start_ff <= start;
			timer_ff <= nxt_timer;
			st1_ff <= nxt_st1;
			st2_ff <= nxt_st2;
			// any channel whose comparator has latched at or above its threshold (remote second outputs after the queue when enabled)
			// comparator release held inside each instance
			ot1_b_ff <= ~|ot1_act;
			ot2_b_ff <= ~|ot2_act;
		end
	end

	assign alert_out = 1'b0;
	assign alert_oe = alert_ff;
	assign first_overtemp_output_b = ot1_b_ff;
	assign second_overtemp_output_b = ot2_b_ff;
	assign conv_start = start_ff;
endmodule
`default_nettype wire

// ### sim/smbus_host.sv
// behavioural bus host master, moving its lines on the falling clock edge
`timescale 1ns/100ps
`default_nettype none
module smbus_host(
	input wire logic mclk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_low
);
	localparam int H = 6;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic hw();
		repeat (H) @(negedge mclk);
	endtask
	// data low before, data low after, clock level at the end
	task automatic cond(input logic a, input logic b, input logic c);
		hw();
		sda_low = a;
		hw();
		scl = 1'b1;
		hw();
		sda_low = b;
		hw();
		scl = c;
	endtask
	task automatic start();
		cond(1'b0, 1'b1, 1'b0);
	endtask
	task automatic stop();
		cond(1'b1, 1'b0, 1'b1);
	endtask
	task automatic bit_io(input logic b, output logic r);
		hw();
		sda_low = !b;
		hw();
		scl = 1'b1;
		hw();
		r = sda_line;
		scl = 1'b0;
	endtask
	task automatic wr(input logic [7:0] d, output logic nak);
		for (int i = 7; i >= 0; i--) bit_io(d[i], nak);
		bit_io(1'b1, nak);
	endtask
	task automatic rd(input logic last, output logic [7:0] d);
		logic a;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, a);
	endtask
endmodule
`default_nettype wire

// ### sim/temp_alarm_asserts.sv
// pin level assertions for the temperature alarm control
`timescale 1ns/100ps
`default_nettype none
module temp_alarm_asserts(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic alert_out,
	input wire logic alert_oe,
	input wire logic first_overtemp_output_b,
	input wire logic second_overtemp_output_b,
	input wire logic conv_start,
	input wire logic conv_done
);
	logic busy_ff, nxt_busy, scl_ff, nxt_scl;
	logic [4:0] age_ff, nxt_age;
	// age counts cycles since the last bus clock rise, saturating
	always_comb begin
		nxt_busy = conv_start | (busy_ff & !conv_done);
		nxt_scl = scl_in;
		nxt_age = age_ff + 5'(age_ff != 5'h1f);
		if (scl_in & !scl_ff) nxt_age = 5'h00;
	end
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			busy_ff <= 1'b0;
			scl_ff <= 1'b1;
			age_ff <= 5'h1f;
		end else begin
			busy_ff <= nxt_busy;
			scl_ff <= nxt_scl;
			age_ff <= nxt_age;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	alert_pin_low_a: assert property (alert_out == 1'b0)
		else $error("alert pin driven high");
	data_pin_low_a: assert property (sda_out == 1'b0)
		else $error("data pin driven high");
	alert_at_conv_a: assert property ($rose(alert_oe) |->
		$past(conv_done) || $past(conv_done, 2) || $past(conv_done, 3))
		else $error("alert raised away from a conversion end");
	alert_clear_bus_a: assert property ($fell(alert_oe) |->
		age_ff != 5'h1f) else $error("alert released without bus access");
	ot1_at_conv_a: assert property ($fell(first_overtemp_output_b) |->
		$past(conv_done, 2) || $past(conv_done, 3) || $past(conv_done, 4))
		else $error("first overtemp set away from a conversion");
	ot2_at_conv_a: assert property ($fell(second_overtemp_output_b) |->
		$past(conv_done, 2) || $past(conv_done, 3) || $past(conv_done, 4))
		else $error("second overtemp set away from a conversion");
	start_pulse_a: assert property (conv_start |=> !conv_start)
		else $error("conversion start longer than one cycle");
	start_idle_a: assert property (conv_start |-> !busy_ff)
		else $error("conversion started while busy");
	sda_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data line moved while bus clock high");
endmodule
`default_nettype wire

// ### sim/tb_temp_sensor_alarm_control.sv
// self-checking bench for the temperature alarm control block
`timescale 1ns/100ps
`default_nettype none
module tb_temp_sensor_alarm_control
	import temp_alarm_pkg::*;
;
	localparam int CONV = 1500;
	localparam logic [6:0] ADDR = 7'h4c;
	logic mclk = 1'b0, rst_b = 1'b0, conv_done = 1'b0, o1 = 1'b0, o2 = 1'b0;
	logic [7:0] lt = 8'h19, r1 = 8'h19, r2 = 8'h19;
	logic scl, sda_low, sda_oe, sda_out, alert_out, alert_oe;
	logic ot1_b, ot2_b, conv_start;
	wire sda = !(sda_low | sda_oe);
	int fails = 0, num_checks = 0, cyc = 0, starts = 0, last_st = 0;
	int prev_st = 0;
	temp_sensor_alarm_control #(.CONV_CYC(CONV), .TIMEOUT_CYC(500)) dut(
		.mclk(mclk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .own_addr(ADDR),
		.alert_out(alert_out), .alert_oe(alert_oe),
		.first_overtemp_output_b(ot1_b), .second_overtemp_output_b(ot2_b),
		.conv_start(conv_start), .conv_done(conv_done), .local_temp(lt),
		.remote1_temp(r1), .remote2_temp(r2), .remote1_open(o1),
		.remote2_open(o2));
	smbus_host host(.mclk(mclk), .sda_line(sda), .scl(scl),
		.sda_low(sda_low));
	initial forever #10 mclk = ~mclk;
	// converter stand-in: results ready 20 cycles after a start
	initial forever begin
		@(negedge mclk);
		if (conv_start === 1'b1) begin
			repeat (20) @(negedge mclk);
			conv_done = 1'b1;
			@(negedge mclk);
			conv_done = 1'b0;
		end
	end
	always @(negedge mclk) begin
		cyc++;
		if (conv_start === 1'b1) begin
			starts++;
			prev_st = last_st;
			last_st = cyc;
		end
		if (cyc == 90000) begin
			fails++;
			tally_and_finish();
		end
	end
	task automatic cmp(input string w, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %0h seen %0h", w, e, g);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic addr_cmd(input logic [7:0] c);
		logic n;
		host.start();
		host.wr({ADDR, 1'b0}, n);
		host.wr(c, n);
	endtask
	task automatic wreg(input logic [7:0] c, input logic [7:0] d);
		logic n;
		addr_cmd(c);
		host.wr(d, n);
		host.stop();
	endtask
	task automatic rcv(input logic [6:0] a, output logic n,
		output logic [7:0] d);
		host.start();
		host.wr({a, 1'b1}, n);
		host.rd(1'b1, d);
		host.stop();
	endtask
	task automatic rreg(input logic [7:0] c, output logic [7:0] d);
		logic n;
		addr_cmd(c);
		rcv(ADDR, n, d);
	endtask
	task automatic one_shot();
		addr_cmd(CMD_ONE_SHOT);
		host.stop();
	endtask
	task automatic wait_conv();
		int n;
		n = 0;
		while (conv_done !== 1'b1 && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		repeat (5) @(negedge mclk);
	endtask
	task automatic t_pointer();
		logic n;
		logic [7:0] d;
		wait_conv();
		rcv(ADDR, n, d);
		cmp("pointer read", 8'h19, d);
		rreg(CMD_CFG_RD, d);
		cmp("cfg reset", 8'h00, d);
		rreg(CMD_OVERTEMP_HYSTERESIS, d);
		cmp("overtemp_hysteresis reset", 8'h0a, d);
	endtask
	task automatic t_alert();
		logic n;
		logic [7:0] d;
		wreg(CMD_OVERTEMP_HYSTERESIS, 8'h05);
		lt = 8'h50;
		wait_conv();
		cmp("alert", 1, alert_oe);
		cmp("ot1", 0, ot1_b);
		rreg(CMD_STATUS1, d);
		cmp("status1", 8'h41, d);
		cmp("alert", 0, alert_oe);
		cmp("ot1", 0, ot1_b);
		wait_conv();
		cmp("alert", 1, alert_oe);
		rcv(ARA_ADDR, n, d);
		cmp("ara ack", 0, n);
		cmp("ara addr", {ADDR, 1'b0}, d);
		cmp("alert", 0, alert_oe);
		wreg(CMD_CFG_WR, 8'h04);
		wait_conv();
		rcv(ARA_ADDR, n, d);
		cmp("ara off", 1, n);
		cmp("alert", 1, alert_oe);
		wreg(CMD_CFG_WR, 8'h00);
		lt = 8'h42;
		wait_conv();
		cmp("ot1 hold", 0, ot1_b);
		lt = 8'h40;
		wait_conv();
		cmp("ot1 free", 1, ot1_b);
		rreg(CMD_STATUS1, d);
	endtask
	task automatic t_mask();
		logic [7:0] d;
		logic [7:0] m[3] = '{8'h01, 8'h02, 8'h80};
		logic [7:0] sr[3] = '{CMD_STATUS1, CMD_STATUS2, CMD_STATUS1};
		logic [7:0] fl[3] = '{8'h04, 8'h10, 8'h41};
		for (int i = 0; i < 3; i++) begin
			// mask first so no unmasked cause reaches a conversion
			wreg(CMD_CFG_WR, m[i]);
			o1 = (i == 0);
			r2 = (i == 1) ? 8'h50 : 8'h19;
			lt = (i == 2) ? 8'h50 : 8'h19;
			rreg(CMD_STATUS1, d);
			wait_conv();
			cmp("masked alert", 0, alert_oe);
			rreg(sr[i], d);
			cmp("masked flag", fl[i], d);
		end
		lt = 8'h19;
		wait_conv();
		rreg(CMD_STATUS1, d);
		wreg(CMD_CFG_WR, 8'h00);
	endtask
	task automatic t_queue();
		logic [7:0] p;
		int run;
		wreg(CMD_CFG_WR, 8'h20);
		for (int c = 0; c < 2; c++) begin
			p = c ? 8'b1111_1101 : 8'b1111_0111;
			run = 0;
			for (int k = 0; k < 8; k++) begin
				if (c == 0) r1 = p[k] ? 8'h78 : 8'h19;
				else r2 = p[k] ? 8'h78 : 8'h19;
				run = p[k] ? run + 1 : 0;
				wait_conv();
				cmp("ot2 queue", run < (c ? 2 : 4), ot2_b);
				if (k == 0) cmp("ot1 now", 0, ot1_b);
			end
			r1 = 8'h19;
			r2 = 8'h19;
			wait_conv();
		end
		wreg(CMD_CFG_WR, 8'h00);
	endtask
	task automatic t_oneshot();
		int s;
		int n;
		logic [7:0] d;
		wait_conv();
		s = starts;
		one_shot();
		cmp("one-shot start", s + 1, starts);
		n = 0;
		while (starts == s + 1 && n < 2 * CONV) begin
			@(negedge mclk);
			n++;
		end
		cmp("rate restart", CONV, last_st - prev_st);
		wreg(CMD_CFG_WR, 8'h40);
		s = starts;
		repeat (CONV + 200) @(negedge mclk);
		cmp("standby", s, starts);
		r2 = 8'h2a;
		one_shot();
		repeat (50) @(negedge mclk);
		cmp("standby one-shot", s + 1, starts);
		repeat (CONV + 200) @(negedge mclk);
		cmp("back to standby", s + 1, starts);
		wreg(CMD_CFG_WR, 8'h48);
		rreg(CMD_REMOTE_TEMP, d);
		cmp("remote 2 select", 8'h2a, d);
	endtask
	initial begin
		repeat (10) @(negedge mclk);
		rst_b = 1'b1;
		t_pointer();
		t_alert();
		t_mask();
		t_queue();
		t_oneshot();
		tally_and_finish();
	end
endmodule
bind temp_sensor_alarm_control temp_alarm_asserts chk_u(.mclk(mclk),
	.rst_b(rst_b), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.alert_out(alert_out), .alert_oe(alert_oe), .conv_start(conv_start),
	.first_overtemp_output_b(first_overtemp_output_b),
	.second_overtemp_output_b(second_overtemp_output_b),
	.conv_done(conv_done));
`default_nettype wire
